// >>> include/dfr_pkg.sv
package dfr_pkg;

  // =====================================================================
  // register indices (function data group)
  // =====================================================================
  localparam logic [1:0] IDX_ACCEL_TIME = 2'h0;
  localparam logic [1:0] IDX_DECEL_TIME = 2'h1;
  localparam logic [1:0] IDX_DRIVE_TORQUE_LIMIT = 2'h2;
  localparam logic [1:0] IDX_BRAKE_TORQUE_LIMIT = 2'h3;
  localparam int NUM_PARAMS = 4;
  localparam int DATA_W = 16;

  // =====================================================================
  // ranges, counts of the least step (0.1 s, 0.01 %)
  // =====================================================================
  localparam logic [15:0] TIME_MIN = 16'h0000;
  localparam logic [15:0] TIME_MAX = 16'h8ca0;
  localparam logic [15:0] TORQUE_MIN = 16'h07d0;
  localparam logic [15:0] TORQUE_MAX = 16'h3a98;
  // special torque code, stored as the raw figure; below TORQUE_MIN
  localparam logic [15:0] TORQUE_SPECIAL = 16'h03e7;
  // times from 100.0 s upward keep whole seconds only
  localparam logic [15:0] TRUNC_FROM = 16'h03e8;
  localparam logic [15:0] TRUNC_STEP = 16'h000a;

  localparam logic [15:0] PARAM_MIN [NUM_PARAMS] =
    '{TIME_MIN, TIME_MIN, TORQUE_MIN, TORQUE_MIN};
  localparam logic [15:0] PARAM_MAX [NUM_PARAMS] =
    '{TIME_MAX, TIME_MAX, TORQUE_MAX, TORQUE_MAX};
  localparam logic [NUM_PARAMS-1:0] PARAM_SPECIAL_EN = 4'hc;
  localparam logic [NUM_PARAMS-1:0] PARAM_TRUNC_EN = 4'h3;

  // =====================================================================
  // reset values
  // =====================================================================
  localparam logic [15:0] RST_ACCEL_TIME = 16'h00c8;
  localparam logic [15:0] RST_DECEL_TIME = 16'h00c8;
  localparam logic [15:0] RST_TORQUE = TORQUE_SPECIAL;

  // =====================================================================
  // link input command assignment codes
  // =====================================================================
  localparam int NUM_SLOTS = 9;
  localparam int NUM_LOOPS = 3;
  localparam int CMDS_PER_LOOP = 5;
  localparam int NUM_LOOP_CMDS = NUM_LOOPS * CMDS_PER_LOOP;
  localparam logic [7:0] LOOP_CODE_BASE [NUM_LOOPS] =
    '{8'hc9, 8'hd3, 8'hdd};
  localparam int CMD_ENABLE = 0;
  localparam int CMD_CANCEL = 1;
  localparam int CMD_INVERT = 2;
  localparam int CMD_CLEAR_TERMS = 3;
  localparam int CMD_HOLD_INTEGRAL = 4;

  // =====================================================================
  // carriers
  // =====================================================================
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] idx;
    logic [15:0] data;
  } dfr_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] data;
  } dfr_rsp_t;

endpackage

// >>> rtl/dfr_cmd_slot.sv
`timescale 1ns/1ps
module dfr_cmd_slot (
  input wire logic [7:0] code,
  input wire logic cmd,
  output logic [dfr_pkg::NUM_LOOP_CMDS-1:0] hits
);
  import dfr_pkg::*;

  // =====================================================================
  // one input slot: assigned code against the loop command codes
  // =====================================================================
  always_comb begin
    hits = '0;
    for (int l = 0; l < NUM_LOOPS; l++) begin
      for (int k = 0; k < CMDS_PER_LOOP; k++) begin
        // link commands are active high, no logic-sense inversion
        hits[l*CMDS_PER_LOOP+k] = cmd &&
          (code == LOOP_CODE_BASE[l] + 8'(k));
      end
    end
  end

endmodule

// >>> rtl/dfr_function_data.sv
`timescale 1ns/1ps
// Summary of operation
// - out-of-range host write is dropped and answered with an error
// - acceleration time accepted 0.0 to 3600.0 s in 0.1 s steps
// - deceleration time accepted 0.0 to 3600.0 s in 0.1 s steps
// - driving torque limit 20.00 to 150.00 %, or special 999
// - braking torque limit 20.00 to 150.00 %, or special 999
// - time writes land in the shared first accel/decel parameters
// - torque limit writes land in the shared internal limits
// - keypad changes show on later host reads
// - long times drop their lowest figure before storing
// - link commands are active high whatever the terminal sense
// - codes 201 to 205, 211 to 215 and 221 to 225 decode loop commands, off when unassigned
// - five commands per external loop, loop two at 211 to 215
module dfr_function_data (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire dfr_pkg::dfr_req_t host_req,
  output dfr_pkg::dfr_rsp_t host_rsp,
  input wire dfr_pkg::dfr_req_t keypad_req,
  output logic keypad_err,
  input wire logic [dfr_pkg::NUM_SLOTS-1:0] link_cmd_word,
  input wire logic [dfr_pkg::NUM_SLOTS-1:0][7:0] slot_code,
  output logic [15:0] accel_time_one_param,
  output logic [15:0] decel_time_one_param,
  output logic [15:0] drive_torque_param,
  output logic [15:0] brake_torque_param,
  output logic ext_loop1_enable,
  output logic ext_loop1_cancel,
  output logic ext_loop1_invert,
  output logic ext_loop1_clear_terms,
  output logic ext_loop1_hold_integral,
  output logic ext_loop2_enable,
  output logic ext_loop2_cancel,
  output logic ext_loop2_invert,
  output logic ext_loop2_clear_terms,
  output logic ext_loop2_hold_integral,
  output logic ext_loop3_enable,
  output logic ext_loop3_cancel,
  output logic ext_loop3_invert,
  output logic ext_loop3_clear_terms,
  output logic ext_loop3_hold_integral
);
  import dfr_pkg::*;

  // =====================================================================
  // reset release
  // =====================================================================
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // =====================================================================
  // value checks, one for each write path
  // =====================================================================
  logic host_ok;
  logic [15:0] host_stored;
  logic kp_ok;
  logic [15:0] kp_stored;

  dfr_value_check u_host_chk (
    .value(host_req.data),
    .lo(PARAM_MIN[host_req.idx]),
    .hi(PARAM_MAX[host_req.idx]),
    .special_en(PARAM_SPECIAL_EN[host_req.idx]),
    .trunc_en(PARAM_TRUNC_EN[host_req.idx]),
    .ok(host_ok),
    .stored(host_stored)
  );

  dfr_value_check u_kp_chk (
    .value(keypad_req.data),
    .lo(PARAM_MIN[keypad_req.idx]),
    .hi(PARAM_MAX[keypad_req.idx]),
    .special_en(PARAM_SPECIAL_EN[keypad_req.idx]),
    .trunc_en(PARAM_TRUNC_EN[keypad_req.idx]),
    .ok(kp_ok),
    .stored(kp_stored)
  );

  logic host_wr;
  logic kp_wr;

  assign host_wr = host_req.valid && host_req.write && host_ok;
  assign kp_wr = keypad_req.valid && keypad_req.write && kp_ok;

  // =====================================================================
  // shared parameter storage
  // =====================================================================
  logic [15:0] param_q [NUM_PARAMS];

  // one location per parameter, so both paths see the same value;
  // on a same-cycle clash the keypad write lands last and wins
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      param_q[IDX_ACCEL_TIME] <= RST_ACCEL_TIME;
      param_q[IDX_DECEL_TIME] <= RST_DECEL_TIME;
      param_q[IDX_DRIVE_TORQUE_LIMIT] <= RST_TORQUE;
      param_q[IDX_BRAKE_TORQUE_LIMIT] <= RST_TORQUE;
    end else begin
      if (host_wr) begin
        param_q[host_req.idx] <= host_stored;
      end
      if (kp_wr) begin
        param_q[keypad_req.idx] <= kp_stored;
      end
    end
  end

  assign accel_time_one_param = param_q[IDX_ACCEL_TIME];
  assign decel_time_one_param = param_q[IDX_DECEL_TIME];
  assign drive_torque_param = param_q[IDX_DRIVE_TORQUE_LIMIT];
  assign brake_torque_param = param_q[IDX_BRAKE_TORQUE_LIMIT];

  // =====================================================================
  // host answer, one cycle after each request
  // =====================================================================
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      host_rsp <= '0;
    end else begin
      host_rsp.valid <= host_req.valid;
      host_rsp.err <= host_req.valid && host_req.write && !host_ok;
      if (!host_req.valid) begin
        host_rsp.data <= 16'h0000;
      end else if (host_req.write) begin
        host_rsp.data <= host_ok ? host_stored : param_q[host_req.idx];
      end else begin
        host_rsp.data <= param_q[host_req.idx];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      keypad_err <= 1'b0;
    end else begin
      keypad_err <= keypad_req.valid && keypad_req.write && !kp_ok;
    end
  end

  // =====================================================================
  // link command decode
  // =====================================================================
  logic [NUM_SLOTS-1:0][NUM_LOOP_CMDS-1:0] slot_hits;
  logic [NUM_LOOP_CMDS-1:0] loop_cmd_d;
  logic [NUM_LOOP_CMDS-1:0] loop_cmd_q;

  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    dfr_cmd_slot u_slot (
      .code(slot_code[s]),
      .cmd(link_cmd_word[s]),
      .hits(slot_hits[s])
    );
  end

  always_comb begin
    loop_cmd_d = '0;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      loop_cmd_d = loop_cmd_d | slot_hits[s];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      loop_cmd_q <= '0;
    end else begin
      loop_cmd_q <= loop_cmd_d;
    end
  end

  assign ext_loop1_enable = loop_cmd_q[0*CMDS_PER_LOOP+CMD_ENABLE];
  assign ext_loop1_cancel = loop_cmd_q[0*CMDS_PER_LOOP+CMD_CANCEL];
  assign ext_loop1_invert = loop_cmd_q[0*CMDS_PER_LOOP+CMD_INVERT];
  assign ext_loop1_clear_terms = loop_cmd_q[0*CMDS_PER_LOOP+CMD_CLEAR_TERMS];
  assign ext_loop1_hold_integral =
    loop_cmd_q[0*CMDS_PER_LOOP+CMD_HOLD_INTEGRAL];
  assign ext_loop2_enable = loop_cmd_q[1*CMDS_PER_LOOP+CMD_ENABLE];
  assign ext_loop2_cancel = loop_cmd_q[1*CMDS_PER_LOOP+CMD_CANCEL];
  assign ext_loop2_invert = loop_cmd_q[1*CMDS_PER_LOOP+CMD_INVERT];
  assign ext_loop2_clear_terms = loop_cmd_q[1*CMDS_PER_LOOP+CMD_CLEAR_TERMS];
  assign ext_loop2_hold_integral =
    loop_cmd_q[1*CMDS_PER_LOOP+CMD_HOLD_INTEGRAL];
  assign ext_loop3_enable = loop_cmd_q[2*CMDS_PER_LOOP+CMD_ENABLE];
  assign ext_loop3_cancel = loop_cmd_q[2*CMDS_PER_LOOP+CMD_CANCEL];
  assign ext_loop3_invert = loop_cmd_q[2*CMDS_PER_LOOP+CMD_INVERT];
  assign ext_loop3_clear_terms = loop_cmd_q[2*CMDS_PER_LOOP+CMD_CLEAR_TERMS];
  assign ext_loop3_hold_integral =
    loop_cmd_q[2*CMDS_PER_LOOP+CMD_HOLD_INTEGRAL];

  // =====================================================================
  // checks
  // =====================================================================
  // helper for the checks: no slot holds any code from 201 to 225, gaps included
  logic codes_idle;

  always_comb begin
    codes_idle = 1'b1;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      if (slot_code[s] >= LOOP_CODE_BASE[0] &&
          slot_code[s] <= LOOP_CODE_BASE[NUM_LOOPS-1] + 8'h04) begin
        codes_idle = 1'b0;
      end
    end
  end

  property p_reject_bad;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (host_req.valid && host_req.write && !host_ok && !kp_wr)
      |=> host_rsp.err &&
          param_q[$past(host_req.idx)] == $past(param_q[host_req.idx]);
  endproperty
  a_reject_bad: assert property (p_reject_bad)
    else $error("bad host write was stored or not flagged");

  property p_time_range;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (host_req.valid && host_req.write && !host_req.idx[1])
      |-> host_ok == (host_req.data <= 16'h8ca0);
  endproperty
  a_time_range: assert property (p_time_range)
    else $error("time range check wrong");

  property p_torque_range;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (host_req.valid && host_req.write && host_req.idx[1])
      |-> host_ok == ((host_req.data >= 16'h07d0 &&
                       host_req.data <= 16'h3a98) ||
                      host_req.data == 16'h03e7);
  endproperty
  a_torque_range: assert property (p_torque_range)
    else $error("torque range check wrong");

  property p_write_lands;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (host_wr && !(kp_wr && keypad_req.idx == host_req.idx))
      |=> param_q[$past(host_req.idx)] == $past(host_stored);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("accepted host write did not update parameter");

  property p_keypad_seen;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (kp_wr ##1 (!host_wr && !kp_wr) ##1
     (host_req.valid && !host_req.write &&
      host_req.idx == $past(keypad_req.idx, 2)))
      |=> host_rsp.data == $past(kp_stored, 3);
  endproperty
  a_keypad_seen: assert property (p_keypad_seen)
    else $error("keypad change not returned on host read");

  property p_truncate;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (host_req.valid && host_req.write && !host_req.idx[1] && host_ok &&
     host_req.data >= 16'h03e8)
      |-> (host_stored % 16'h000a) == 16'h0000 &&
          host_req.data - host_stored < 16'h000a;
  endproperty
  a_truncate: assert property (p_truncate)
    else $error("long time not cut to whole seconds");

  property p_loop2_enable;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (link_cmd_word[0] && slot_code[0] == 8'hd3) |=> ext_loop2_enable;
  endproperty
  a_loop2_enable: assert property (p_loop2_enable)
    else $error("loop two enable not decoded from its code");

  property p_unassigned_off;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    codes_idle |=> loop_cmd_q == '0 && !ext_loop3_hold_integral;
  endproperty
  a_unassigned_off: assert property (p_unassigned_off)
    else $error("loop command active without an assigned input");

  // a low command bit must never act, whatever code its slot holds
  property p_link_low;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (link_cmd_word == '0) |=> loop_cmd_q == '0;
  endproperty
  a_link_low: assert property (p_link_low)
    else $error("loop command active with all command bits low");

  property p_answer_once;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    host_req.valid |=> host_rsp.valid && host_rsp.data <= TIME_MAX;
  endproperty
  a_answer_once: assert property (p_answer_once)
    else $error("host request not answered next cycle");

  property p_kp_reject;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (keypad_req.valid && keypad_req.write && !kp_ok && !host_wr)
      |=> keypad_err &&
          param_q[$past(keypad_req.idx)] == $past(param_q[keypad_req.idx]);
  endproperty
  a_kp_reject: assert property (p_kp_reject)
    else $error("bad keypad write was stored or not flagged");

  // an answer without a request would look like a fresh error to the host
  property p_rsp_idle;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    !host_req.valid |=> !host_rsp.valid && !host_rsp.err &&
      host_rsp.data == 16'h0000;
  endproperty
  a_rsp_idle: assert property (p_rsp_idle)
    else $error("host answer seen without a request");

endmodule

// >>> rtl/dfr_value_check.sv
`timescale 1ns/1ps
module dfr_value_check (
  input wire logic [15:0] value,
  input wire logic [15:0] lo,
  input wire logic [15:0] hi,
  input wire logic special_en,
  input wire logic trunc_en,
  output logic ok,
  output logic [15:0] stored
);
  import dfr_pkg::*;

  // =====================================================================
  // range check and truncation
  // =====================================================================
  logic [15:0] rem;

  always_comb begin
    rem = value % TRUNC_STEP;
    ok = ((value >= lo) && (value <= hi)) ||
         (special_en && (value == TORQUE_SPECIAL));
    // constant modulus, so this folds into a small lookup-free divider
    if (trunc_en && (value >= TRUNC_FROM)) begin
      stored = value - rem;
    end else begin
      stored = value;
    end
  end

endmodule

// >>> verification/dfr_host_model.sv
`timescale 1ns/1ps
module dfr_host_model (
  input wire logic sys_clk,
  input wire dfr_pkg::dfr_rsp_t host_rsp,
  output dfr_pkg::dfr_req_t host_req
);
  import dfr_pkg::*;
  // ===================================================================
  // host side of the link, one request at a time
  // ===================================================================
  initial begin
    host_req = '0;
  end
  // the answer stands one cycle only, so it is looked at in that cycle
  task automatic xfer(input logic wr, input logic [1:0] idx,
      input logic [15:0] data, output logic err, output logic [15:0] rd,
      output logic vld);
    @(negedge sys_clk);
    host_req = '{valid: 1'b1, write: wr, idx: idx, data: data};
    @(posedge sys_clk);
    @(negedge sys_clk);
    vld = host_rsp.valid;
    err = host_rsp.err;
    rd = host_rsp.data;
    host_req.valid = 1'b0;
    // released lines show the inverse, so stale data cannot pass as new
    host_req.data = ~data;
  endtask
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dfr_pkg::*;
  logic sys_clk;
  logic rst_n;
  dfr_req_t host_req;
  dfr_req_t keypad_req;
  dfr_rsp_t host_rsp;
  logic keypad_err;
  logic [NUM_SLOTS-1:0] link_cmd_word;
  logic [NUM_SLOTS-1:0][7:0] slot_code;
  logic [3:0][15:0] par;
  logic [14:0] lp;
  logic [15:0] shadow [NUM_PARAMS];
  logic [15:0] corner [11];
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;

  dfr_function_data dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .host_req(host_req),
    .host_rsp(host_rsp), .keypad_req(keypad_req), .keypad_err(keypad_err),
    .link_cmd_word(link_cmd_word), .slot_code(slot_code),
    .accel_time_one_param(par[0]), .decel_time_one_param(par[1]),
    .drive_torque_param(par[2]), .brake_torque_param(par[3]),
    .ext_loop1_enable(lp[0]), .ext_loop1_cancel(lp[1]),
    .ext_loop1_invert(lp[2]), .ext_loop1_clear_terms(lp[3]),
    .ext_loop1_hold_integral(lp[4]), .ext_loop2_enable(lp[5]),
    .ext_loop2_cancel(lp[6]), .ext_loop2_invert(lp[7]),
    .ext_loop2_clear_terms(lp[8]), .ext_loop2_hold_integral(lp[9]),
    .ext_loop3_enable(lp[10]), .ext_loop3_cancel(lp[11]),
    .ext_loop3_invert(lp[12]), .ext_loop3_clear_terms(lp[13]),
    .ext_loop3_hold_integral(lp[14])
  );

  dfr_host_model host (
    .sys_clk(sys_clk), .host_rsp(host_rsp), .host_req(host_req)
  );

  // ===================================================================
  // checking helpers
  // ===================================================================
  task automatic stop_test;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // {accepted, stored value}
  function automatic logic [16:0] expect_wr(input logic [1:0] i,
      input logic [15:0] v);
    logic ok;
    logic [15:0] s;
    s = v;
    if (i < 2'h2) begin
      ok = (v <= TIME_MAX);
      if (v >= TRUNC_FROM) s = v - (v % TRUNC_STEP);
    end else begin
      ok = (v >= TORQUE_MIN && v <= TORQUE_MAX) || v == TORQUE_SPECIAL;
    end
    return {ok, s};
  endfunction

  function automatic logic [14:0] expect_loop(input logic [7:0] code,
      input logic cmd);
    logic [14:0] r;
    r = '0;
    for (int l = 0; l < NUM_LOOPS; l++) begin
      if (cmd && code >= LOOP_CODE_BASE[l] && code < LOOP_CODE_BASE[l] + 5)
        r[l * 5 + int'(code - LOOP_CODE_BASE[l])] = 1'b1;
    end
    return r;
  endfunction

  // ===================================================================
  // bus tasks
  // ===================================================================
  task automatic host_rd(input logic [1:0] i);
    logic err, vld;
    logic [15:0] rd;
    host.xfer(1'b0, i, 16'h0000, err, rd, vld);
    chk("read_data", shadow[i], rd);
  endtask

  task automatic host_wr(input logic [1:0] i, input logic [15:0] v);
    logic err, vld;
    logic [15:0] rd;
    logic [16:0] e;
    e = expect_wr(i, v);
    host.xfer(1'b1, i, v, err, rd, vld);
    chk("rsp_valid", 16'h0001, {15'h0, vld});
    chk("rsp_err", {15'h0, ~e[16]}, {15'h0, err});
    if (e[16]) shadow[i] = e[15:0];
    chk("rsp_data", shadow[i], rd);
    chk("param", shadow[i], par[i]);
    host_rd(i);
  endtask

  task automatic kp_wr(input logic [1:0] i, input logic [15:0] v);
    logic [16:0] e;
    e = expect_wr(i, v);
    @(negedge sys_clk);
    keypad_req = '{valid: 1'b1, write: 1'b1, idx: i, data: v};
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("keypad_err", {15'h0, ~e[16]}, {15'h0, keypad_err});
    keypad_req.valid = 1'b0;
    keypad_req.data = ~v;
    if (e[16]) shadow[i] = e[15:0];
    chk("keypad_param", shadow[i], par[i]);
    host_rd(i);
  endtask

  // other slots carry random command bits but no code, so they add nothing
  task automatic link(input logic [7:0] code, input logic cmd, input int s);
    logic [NUM_SLOTS-1:0][7:0] codes;
    logic [NUM_SLOTS-1:0] bits;
    logic [14:0] e;
    codes = '0;
    codes[s] = code;
    bits = NUM_SLOTS'($urandom);
    bits[s] = cmd;
    e = expect_loop(code, cmd);
    @(negedge sys_clk);
    slot_code = codes;
    link_cmd_word = bits;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("loop_cmds", {1'b0, e}, {1'b0, lp});
  endtask

  // ===================================================================
  // clock, timeout, sequence
  // ===================================================================
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    keypad_req = '0;
    link_cmd_word = '0;
    slot_code = '0;
    corner = '{16'h0000, TIME_MAX, TIME_MAX + 16'h0001, TORQUE_MIN,
      TORQUE_MIN - 16'h0001, TORQUE_MAX, TORQUE_MAX + 16'h0001,
      TORQUE_SPECIAL, TRUNC_FROM - 16'h0001, 16'h04d2, 16'hffff};
    void'($urandom(32871));
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    shadow = '{RST_ACCEL_TIME, RST_DECEL_TIME, RST_TORQUE, RST_TORQUE};
    chk("reset_loops", 16'h0000, {1'b0, lp});
    for (int i = 0; i < NUM_PARAMS; i++) begin
      chk("reset_param", shadow[i], par[i]);
      host_rd(2'(i));
    end
    for (int i = 0; i < NUM_PARAMS; i++) begin
      for (int k = 0; k < 11; k++) host_wr(2'(i), corner[k]);
    end
    repeat (60) host_wr(2'($urandom_range(0, 3)),
      16'($urandom_range(0, 40000)));
    kp_wr(2'h3, 16'h1388);
    kp_wr(2'h0, TIME_MAX + 16'h0001);
    kp_wr(2'h1, 16'h04d2);
    repeat (20) kp_wr(2'($urandom_range(0, 3)),
      16'($urandom_range(0, 40000)));
    for (int c = 200; c <= 226; c++) begin
      link(8'(c), 1'b1, $urandom_range(0, NUM_SLOTS - 1));
      link(8'(c), 1'b0, $urandom_range(0, NUM_SLOTS - 1));
    end
    link(8'hd3, 1'b1, 0);
    link(8'hd3, 1'b0, 0);
    stop_test();
  end
endmodule
